// ### logic/emd_datapath.sv
`timescale 1ns/1ns
`include "emd_params.svh"

module emd_datapath (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // array read side
    input wire logic I_ECC_INPUT_LATCH,
    input wire logic I_READ_OP,
    input wire emd_pkg::emd_cw_s I_RD_WORD,
    input wire logic [31:0] I_WR_DATA,
    // array write side
    output emd_pkg::emd_cw_s O_WR_WORD,
    output logic O_WR_VALID,
    // corrected internal bus
    output logic [31:0] O_INT_BUS,
    output logic O_ECC_OUTPUT_DRIVE,
    output logic [6:0] O_SYNDROME,
    output logic O_ECC_ANY_ERROR,
    output logic O_ECC_SINGLE_ERROR,
    output logic O_ECC_DOUBLE_ERROR,
    // control registers and address
    input wire logic [31:0] I_ERROR_LOG_REG,
    input wire logic [31:0] I_MODE_CONTROL_REG,
    input wire logic [31:0] I_AUX_ADDR_HOLD,
    output logic O_PAGE_MATCH_FLAG,
    output logic O_ERROR_ADDR_MATCH,
    // address slice mux
    input wire logic [1:0] I_SLICE_SELECT,
    output logic [7:0] O_ADDR_SLICE_BUS,
    output logic [15:0] O_ROW_COL_ADDR,
    // boot rom
    input wire logic I_BOOT_CLEAR,
    input wire logic I_NIBBLE_LATCH_STROBE,
    input wire logic [3:0] I_BOOT_NIBBLE_IN,
    output logic O_BOOT_WORD_FULL,
    // processor data
    input wire logic [1:0] I_OUT_SOURCE_SELECT,
    output logic [31:0] O_PROC_DATA
);
    import emd_pkg::*;

    typedef struct packed {
        emd_op_e op;
        emd_cw_s cw;
        logic [31:0] int_bus;
        logic int_valid;
        logic [6:0] syn;
        logic any_err;
        logic single_err;
        logic double_err;
        emd_cw_s wr;
        logic wr_valid;
        logic page_hit;
        logic err_hit;
        logic [7:0] slice_bus;
        logic [15:0] row_col;
        logic [31:0] proc_data;
        logic [3:0] nib_s1;
        logic [3:0] nib_s2;
        logic stb_d1;
        logic stb_d2;
        logic clr_d1;
        logic clr_d2;
    } emd_dp_s;

    emd_dp_s st_reg;
    emd_dp_s st_next;

    logic [6:0] part_lo;
    logic [6:0] syn_now;
    logic [6:0] cin;
    logic fix;
    logic [15:0] fixed_lo;
    logic [15:0] fixed_hi;
    logic [31:0] rom_word;
    logic addr_eq;

    //////////////////////////////////////////////////////////////////////
    // ecc slices
    //////////////////////////////////////////////////////////////////////

    // writes start from a cleared check register
    assign cin = (st_reg.op == OP_READ) ? st_reg.cw.check : 7'h00;
    assign fix = (syn_now != 7'h00) && (^syn_now);

    emd_ecc_slice #(.BASE(5'h00), .FINAL(1'b0)) u_slice_lo (
        .i_data(st_reg.cw.data[15:0]),
        .i_part(cin),
        .o_part(part_lo),
        .i_syn(syn_now),
        .i_fix(fix),
        .o_data(fixed_lo)
    );

    emd_ecc_slice #(.BASE(5'h10), .FINAL(1'b1)) u_slice_hi (
        .i_data(st_reg.cw.data[31:16]),
        .i_part(part_lo),
        .o_part(syn_now),
        .i_syn(syn_now),
        .i_fix(fix),
        .o_data(fixed_hi)
    );

    emd_boot_asm u_boot (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_clear(st_reg.clr_d2),
        .i_strobe(st_reg.stb_d2),
        .i_nibble(st_reg.nib_s2),
        .o_word(rom_word),
        .o_full(O_BOOT_WORD_FULL)
    );

    // page number only; bit 0 of byte 1 is no address bit
    assign addr_eq = ((I_MODE_CONTROL_REG ^ I_AUX_ADDR_HOLD)
        & `EMD_PAGE_MASK) == 32'h00000000;

    //////////////////////////////////////////////////////////////////////
    // next state
    //////////////////////////////////////////////////////////////////////

    always_comb begin
        st_next = st_reg;
        st_next.int_valid = 1'b0;
        st_next.wr_valid = 1'b0;

        // read wins if both arrive; controller never issues both
        if (I_ECC_INPUT_LATCH) begin
            st_next.op = I_READ_OP ? OP_READ : OP_WRITE;
            st_next.cw.data = I_READ_OP ? I_RD_WORD.data : I_WR_DATA;
            st_next.cw.check = I_RD_WORD.check;
        end else begin
            st_next.op = OP_IDLE;
        end

        unique case (st_reg.op)
            OP_IDLE: begin
            end
            OP_READ: begin
                st_next.int_bus = {fixed_hi, fixed_lo};
                st_next.int_valid = 1'b1;
                st_next.syn = syn_now;
                st_next.any_err = (syn_now != 7'h00);
                st_next.single_err = ^syn_now;
                st_next.double_err = (syn_now != 7'h00)
                    && !(^syn_now);
                // uncorrectable word goes back exactly as read
                if ((syn_now != 7'h00) && !(^syn_now)) begin
                    st_next.wr = st_reg.cw;
                    st_next.wr_valid = 1'b1;
                end
                st_next.err_hit = ((I_ERROR_LOG_REG ^ I_AUX_ADDR_HOLD)
                    & `EMD_PAGE_MASK) == 32'h00000000
                    && (I_ERROR_LOG_REG[`EMD_SYN_LSB +: 7] == syn_now);
            end
            OP_WRITE: begin
                st_next.wr.data = st_reg.cw.data;
                st_next.wr.check = syn_now;
                st_next.wr_valid = 1'b1;
            end
            default: begin
            end
        endcase

        st_next.page_hit = addr_eq;

        // address slices; row/column held from bytes 0 and 1
        unique case (I_SLICE_SELECT)
            2'h0: begin
                st_next.slice_bus = I_AUX_ADDR_HOLD[7:0];
                st_next.row_col[7:0] = I_AUX_ADDR_HOLD[7:0];
            end
            2'h1: begin
                st_next.slice_bus = I_AUX_ADDR_HOLD[15:8];
                st_next.row_col[15:8] = I_AUX_ADDR_HOLD[15:8];
            end
            2'h2: begin
                st_next.slice_bus = I_AUX_ADDR_HOLD[23:16];
            end
            2'h3: begin
                st_next.slice_bus = {1'b0,
                    I_ERROR_LOG_REG[`EMD_ERR_FLAG_LSB +: 3],
                    I_MODE_CONTROL_REG[`EMD_MODE_BITS_LSB +: 4]};
            end
        endcase

        unique case (I_OUT_SOURCE_SELECT)
            `EMD_SRC_ARRAY: st_next.proc_data = st_reg.int_bus;
            `EMD_SRC_ROM: st_next.proc_data = rom_word;
            `EMD_SRC_ERRLOG: st_next.proc_data = I_ERROR_LOG_REG;
            `EMD_SRC_MODE: st_next.proc_data = I_MODE_CONTROL_REG;
        endcase

        // prom pins synchronised; strobe delayed to stay aligned
        st_next.nib_s1 = I_BOOT_NIBBLE_IN;
        st_next.nib_s2 = st_reg.nib_s1;
        st_next.stb_d1 = I_NIBBLE_LATCH_STROBE;
        st_next.stb_d2 = st_reg.stb_d1;
        st_next.clr_d1 = I_BOOT_CLEAR;
        st_next.clr_d2 = st_reg.clr_d1;
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs
    //////////////////////////////////////////////////////////////////////

    assign O_WR_WORD = st_reg.wr;
    assign O_WR_VALID = st_reg.wr_valid;
    assign O_INT_BUS = st_reg.int_bus;
    assign O_ECC_OUTPUT_DRIVE = st_reg.int_valid;
    assign O_SYNDROME = st_reg.syn;
    assign O_ECC_ANY_ERROR = st_reg.any_err;
    assign O_ECC_SINGLE_ERROR = st_reg.single_err;
    assign O_ECC_DOUBLE_ERROR = st_reg.double_err;
    assign O_PAGE_MATCH_FLAG = st_reg.page_hit;
    assign O_ERROR_ADDR_MATCH = st_reg.err_hit;
    assign O_ADDR_SLICE_BUS = st_reg.slice_bus;
    assign O_ROW_COL_ADDR = st_reg.row_col;
    assign O_PROC_DATA = st_reg.proc_data;

    //////////////////////////////////////////////////////////////////////
    // assertions
    //////////////////////////////////////////////////////////////////////

    // the release edge itself still holds the flops in reset
    property p_page_match;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_RESET_N
            && (I_MODE_CONTROL_REG[23:9] == I_AUX_ADDR_HOLD[23:9])
            |=> O_PAGE_MATCH_FLAG;
    endproperty
    a_page_match: assert property (p_page_match)
        else $error("page match flag missing");

    property p_page_ignore;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_MODE_CONTROL_REG[23:9] != I_AUX_ADDR_HOLD[23:9])
            |=> !O_PAGE_MATCH_FLAG;
    endproperty
    a_page_ignore: assert property (p_page_ignore)
        else $error("page match raised on differing page");

    property p_err_match;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        O_ECC_OUTPUT_DRIVE |-> O_ERROR_ADDR_MATCH ==
            ((($past(I_ERROR_LOG_REG[23:9]) == $past(I_AUX_ADDR_HOLD[23:9]))
            && ($past(I_ERROR_LOG_REG[6:0]) == O_SYNDROME)));
    endproperty
    a_err_match: assert property (p_err_match)
        else $error("error address match wrong");

    property p_slice_row;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_SLICE_SELECT == 2'h1) |=> (O_ADDR_SLICE_BUS ==
            $past(I_AUX_ADDR_HOLD[15:8])) && (O_ROW_COL_ADDR[15:8] ==
            O_ADDR_SLICE_BUS);
    endproperty
    a_slice_row: assert property (p_slice_row)
        else $error("slice byte 1 not forwarded");

    property p_slice_ctrl;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_RESET_N && (I_SLICE_SELECT == 2'h3) |=> O_ADDR_SLICE_BUS == {1'b0,
            $past(I_ERROR_LOG_REG[31:29]), $past(I_MODE_CONTROL_REG[28:25])};
    endproperty
    a_slice_ctrl: assert property (p_slice_ctrl)
        else $error("control byte on slice bus wrong");

    property p_src_rom;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_OUT_SOURCE_SELECT == 2'h1) |=> O_PROC_DATA == $past(rom_word);
    endproperty
    a_src_rom: assert property (p_src_rom)
        else $error("rom word not on processor data");

    property p_read_done;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_ECC_INPUT_LATCH && I_READ_OP) |=> ##1 O_ECC_OUTPUT_DRIVE;
    endproperty
    a_read_done: assert property (p_read_done)
        else $error("read result not driven two cycles after latch");

    property p_clean_read;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (O_ECC_OUTPUT_DRIVE && O_SYNDROME == 7'h00)
            |-> O_INT_BUS == $past(st_reg.cw.data) && !O_ECC_ANY_ERROR;
    endproperty
    a_clean_read: assert property (p_clean_read)
        else $error("clean read altered data");

    property p_flags;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        O_ECC_OUTPUT_DRIVE |-> (O_ECC_ANY_ERROR == (O_SYNDROME != 7'h00))
            && (O_ECC_SINGLE_ERROR == ^O_SYNDROME);
    endproperty
    a_flags: assert property (p_flags)
        else $error("error flags disagree with syndrome");

    property p_single_fix;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (O_ECC_OUTPUT_DRIVE && O_ECC_SINGLE_ERROR)
            |-> $countones(O_INT_BUS ^ $past(st_reg.cw.data)) <= 1;
    endproperty
    a_single_fix: assert property (p_single_fix)
        else $error("correction flipped more than one bit");

    property p_rewrite;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (O_ECC_OUTPUT_DRIVE && O_ECC_DOUBLE_ERROR) |-> O_WR_VALID
            && O_WR_WORD == $past(st_reg.cw)
            && O_INT_BUS == $past(st_reg.cw.data);
    endproperty
    a_rewrite: assert property (p_rewrite)
        else $error("uncorrectable word not rewritten");

    property p_gen;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_ECC_INPUT_LATCH && !I_READ_OP) |=> ##1 O_WR_VALID
            && O_WR_WORD.data == $past(I_WR_DATA, 2)
            && O_WR_WORD.check[0] == ^(O_WR_WORD.data & `EMD_MASK_S1)
            && O_WR_WORD.check[2] == !(^(O_WR_WORD.data & `EMD_MASK_S4));
    endproperty
    a_gen: assert property (p_gen)
        else $error("generated check bits wrong");

endmodule : emd_datapath

// ### logic/emd_params.svh
`ifndef EMD_PARAMS_SVH
`define EMD_PARAMS_SVH

// syndrome coverage masks over data bits 31..0
`define EMD_MASK_S1 32'hAAAAAAAA
`define EMD_MASK_S2 32'hCCCCCCCC
`define EMD_MASK_S4 32'hF0F0F0F0
`define EMD_MASK_S8 32'hFF00FFFF
`define EMD_MASK_S16 32'hFFFF00FF
`define EMD_MASK_S32 32'hFFFFFF00
`define EMD_MASK_ST 32'h96696969
// check bits 4, 8, 16 and 32 are odd parity
`define EMD_ODD_CHECK 7'h3C
// page address field, byte 1 minus bit 0 plus byte 2
`define EMD_PAGE_MASK 32'h00FFFE00
`define EMD_SYN_LSB 0
`define EMD_ERR_FLAG_LSB 29
`define EMD_MODE_BITS_LSB 25
// output source and slice select codes
`define EMD_SRC_ARRAY 2'h0
`define EMD_SRC_ROM 2'h1
`define EMD_SRC_ERRLOG 2'h2
`define EMD_SRC_MODE 2'h3
`define EMD_SLICE_CTRL 2'h3
`define EMD_NIBBLES 8

`endif

// ### logic/emd_pkg.sv
`include "emd_params.svh"

package emd_pkg;

    typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} emd_op_e;

    // data word with its seven check bits
    typedef struct packed {
        logic [31:0] data;
        logic [6:0] check;
    } emd_cw_s;

    // syndrome bit order: T,32,16,8,4,2,1
    function automatic logic [6:0] emd_cov(input logic [4:0] idx);
        logic [31:0] sel;
        sel = 32'h00000001 << idx;
        emd_cov = {|(sel & `EMD_MASK_ST), |(sel & `EMD_MASK_S32),
            |(sel & `EMD_MASK_S16), |(sel & `EMD_MASK_S8),
            |(sel & `EMD_MASK_S4), |(sel & `EMD_MASK_S2),
            |(sel & `EMD_MASK_S1)};
    endfunction : emd_cov

endpackage : emd_pkg

// ### logic/emd_ecc_slice.sv
`timescale 1ns/1ns
`include "emd_params.svh"

module emd_ecc_slice #(
    parameter logic [4:0] BASE = 5'h00,
    parameter bit FINAL = 1'b0
) (
    // word half and chained partial result
    input wire logic [15:0] i_data,
    input wire logic [6:0] i_part,
    output logic [6:0] o_part,
    // correction
    input wire logic [6:0] i_syn,
    input wire logic i_fix,
    output logic [15:0] o_data
);
    import emd_pkg::*;

    always_comb begin
        logic [6:0] acc;
        acc = i_part;
        for (int i = 0; i < 16; i++) begin
            if (i_data[i]) begin
                acc = acc ^ emd_cov(BASE + 5'(i));
            end
        end
        // only the last slice folds in the odd-parity sense
        o_part = FINAL ? (acc ^ `EMD_ODD_CHECK) : acc;
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            // check-bit errors match no data pattern, data stays intact
            o_data[i] = i_data[i] ^
                (i_fix && (i_syn == emd_cov(BASE + 5'(i))));
        end
    end

endmodule : emd_ecc_slice

// ### logic/emd_boot_asm.sv
`timescale 1ns/1ns
`include "emd_params.svh"

module emd_boot_asm (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // nibble stream
    input wire logic i_clear,
    input wire logic i_strobe,
    input wire logic [3:0] i_nibble,
    // assembled word
    output logic [31:0] o_word,
    output logic o_full
);
    import emd_pkg::*;

    typedef struct packed {
        logic [2:0] idx;
        logic [31:0] word;
        logic full;
    } emd_boot_s;

    emd_boot_s st_reg;
    emd_boot_s st_next;

    always_comb begin
        st_next = st_reg;
        if (i_clear) begin
            st_next = '0;
        end else if (i_strobe) begin
            // one holding register per step, two per slice
            st_next.word[{st_reg.idx, 2'h0} +: 4] = i_nibble;
            st_next.idx = st_reg.idx + 3'h1;
            st_next.full = (st_reg.idx == 3'(`EMD_NIBBLES - 1));
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_word = st_reg.word;
    assign o_full = st_reg.full;

    property p_boot_step;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_strobe && !i_clear) |=> (st_reg.idx == $past(st_reg.idx) + 3'h1)
            && (o_word[{$past(st_reg.idx), 2'h0} +: 4] == $past(i_nibble));
    endproperty
    a_boot_step: assert property (p_boot_step)
        else $error("boot nibble not stored in its own register");

endmodule : emd_boot_asm

// ### tb/emd_mem_model.sv
`timescale 1ns/1ns

module emd_mem_model (
    // clock
    input wire logic i_clk,
    // write from the datapath
    input wire logic i_wr_valid,
    input wire emd_pkg::emd_cw_s i_wr_word,
    // read towards the datapath
    input wire logic [38:0] i_flip,
    output emd_pkg::emd_cw_s o_rd_word
);
    import emd_pkg::*;

    emd_cw_s mem_reg;

    ////////////////////////////////////////////////////////////////////////
    // one cell is enough: each read returns the last word written
    always_ff @(posedge i_clk) begin
        if (i_wr_valid) begin
            mem_reg <= i_wr_word;
        end
    end

    // flips stand for cell faults that the bench commands
    assign o_rd_word = emd_cw_s'(mem_reg ^ i_flip);

endmodule : emd_mem_model

// ### tb/emd_datapath_bench.sv
`timescale 1ns/1ns

module emd_datapath_bench;
    import emd_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic latch = 1'b0;
    logic read_op = 1'b0;
    logic [31:0] wr_data = 32'h00000000;
    logic [31:0] err_log = 32'h00000000;
    logic [31:0] mode_reg = 32'h00000000;
    logic [31:0] aux = 32'h00000000;
    logic [1:0] slice_sel = 2'h0;
    logic boot_clr = 1'b0;
    logic strobe = 1'b0;
    logic [3:0] nibble = 4'h0;
    logic [1:0] src_sel = 2'h0;
    logic [38:0] flip = 39'h0;
    emd_cw_s rd_word;
    emd_cw_s wr_word;
    logic wr_valid, out_drive, any_err, single_err, double_err;
    logic page_hit, err_hit, full;
    logic [31:0] int_bus, proc_data, exp_d;
    logic [31:0] boot_pat = 32'h9E3C5A71;
    logic [6:0] syndrome;
    logic [7:0] slice_bus;
    logic [15:0] row_col;
    logic odd, dbl;
    int n_errors = 0;
    int cmp_count = 0;

    ////////////////////////////////////////////////////////////////////////
    // rows: written data, injected fault, syndrome it should give
    logic [31:0] row_data [7] = '{32'h00000000, 32'hFFFFFFFF,
        32'h12345678, 32'hA5A5A5A5, 32'h0F0F0F0F, 32'hC3C3C3C3,
        32'h5A5A5A5A};
    logic [38:0] row_flip [7] = '{39'h0, 39'h80, 39'h100,
        39'h4000000000, 39'h02, 39'h180, 39'h40};
    logic [6:0] row_syn [7] = '{7'h00, 7'h58, 7'h19, 7'h7F, 7'h02,
        7'h41, 7'h40};
    // page compare: hit expected beside the address
    logic [32:0] pg_rows [4] = '{{1'b1, 32'h00ABCC00},
        {1'b1, 32'hA1ABCDC3}, {1'b0, 32'h00ABCE00}, {1'b0, 32'h002BCC00}};

    emd_datapath u_dut (
        .I_CLK(clk), .I_RESET_N(rst_n),
        .I_ECC_INPUT_LATCH(latch), .I_READ_OP(read_op),
        .I_RD_WORD(rd_word), .I_WR_DATA(wr_data),
        .O_WR_WORD(wr_word), .O_WR_VALID(wr_valid),
        .O_INT_BUS(int_bus), .O_ECC_OUTPUT_DRIVE(out_drive),
        .O_SYNDROME(syndrome), .O_ECC_ANY_ERROR(any_err),
        .O_ECC_SINGLE_ERROR(single_err), .O_ECC_DOUBLE_ERROR(double_err),
        .I_ERROR_LOG_REG(err_log), .I_MODE_CONTROL_REG(mode_reg),
        .I_AUX_ADDR_HOLD(aux), .O_PAGE_MATCH_FLAG(page_hit),
        .O_ERROR_ADDR_MATCH(err_hit), .I_SLICE_SELECT(slice_sel),
        .O_ADDR_SLICE_BUS(slice_bus), .O_ROW_COL_ADDR(row_col),
        .I_BOOT_CLEAR(boot_clr), .I_NIBBLE_LATCH_STROBE(strobe),
        .I_BOOT_NIBBLE_IN(nibble), .O_BOOT_WORD_FULL(full),
        .I_OUT_SOURCE_SELECT(src_sel), .O_PROC_DATA(proc_data)
    );

    emd_mem_model u_mem (
        .i_clk(clk), .i_wr_valid(wr_valid), .i_wr_word(wr_word),
        .i_flip(flip), .o_rd_word(rd_word)
    );

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // odd-parity groups are the inverted ones
    function automatic logic [6:0] gen_check(input logic [31:0] d);
        gen_check = {^(d & 32'h96696969), ^(d & 32'hFFFFFF00),
            ^(d & 32'hFFFF00FF), ^(d & 32'hFF00FFFF),
            ^(d & 32'hF0F0F0F0), ^(d & 32'hCCCCCCCC),
            ^(d & 32'hAAAAAAAA)} ^ 7'h3C;
    endfunction : gen_check

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    task automatic complete_run;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // let the edge land, then look
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    // result pulses exactly one edge after the take edge
    task automatic ecc_op(input logic rd, input logic [31:0] d);
        @(posedge clk);
        latch <= 1'b1;
        read_op <= rd;
        wr_data <= d;
        @(posedge clk);
        latch <= 1'b0;
        step();
    endtask : ecc_op

    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({int_bus, syndrome, out_drive, wr_valid, any_err, page_hit,
            err_hit, full}, 64'h0);
        check(proc_data, 32'h0);
    endtask : do_reset

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        @(posedge clk);
        aux <= 32'h00ABCD00;
        for (int i = 0; i < 7; i++) begin
            flip <= 39'h0;
            ecc_op(1'b0, row_data[i]);
            check(wr_valid, 1'b1);
            check(wr_word, {row_data[i], gen_check(row_data[i])});
            @(posedge clk);
            flip <= row_flip[i];
            err_log <= 32'h00ABCC00 | row_syn[i];
            ecc_op(1'b1, 32'h0);
            odd = ^row_syn[i];
            dbl = (row_syn[i] != 7'h00) && !odd;
            exp_d = dbl ? row_data[i] ^ row_flip[i][38:7] : row_data[i];
            check(out_drive, 1'b1);
            check(syndrome, row_syn[i]);
            check(int_bus, exp_d);
            check({any_err, single_err, double_err},
                {row_syn[i] != 7'h00, odd, dbl});
            check(wr_valid, dbl);
            if (dbl) begin
                check(wr_word, {row_data[i], gen_check(row_data[i])}
                    ^ row_flip[i]);
            end
            check(err_hit, 1'b1);
        end
        // wrong page bit 9, then wrong logged syndrome
        flip <= 39'h0;
        foreach (pg_rows[j]) begin
            if (j < 2) begin
                @(posedge clk);
                err_log <= (j == 0) ? 32'h00ABCE00 : 32'h00ABCC11;
                ecc_op(1'b1, 32'h0);
                check(err_hit, 1'b0);
            end
        end
        @(posedge clk);
        mode_reg <= 32'h5EABCD3C;
        foreach (pg_rows[j]) begin
            @(posedge clk);
            aux <= pg_rows[j][31:0];
            step();
            check(page_hit, pg_rows[j][32]);
        end
        // neighbours of the control fields are set to catch bad slicing
        @(posedge clk);
        aux <= 32'h89ABCDEF;
        mode_reg <= 32'hB3ABCD3C;
        err_log <= 32'h50000000;
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            slice_sel <= s[1:0];
            step();
            check(slice_bus, (s == 3) ? {1'b0, err_log[31:29],
                mode_reg[28:25]} : aux[8 * s +: 8]);
        end
        check(row_col, aux[15:0]);
        // boot word: clear, eight back-to-back nibbles, then a wrap
        @(posedge clk);
        boot_clr <= 1'b1;
        src_sel <= 2'h1;
        @(posedge clk);
        boot_clr <= 1'b0;
        repeat (4) step();
        check(full, 1'b0);
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            strobe <= 1'b1;
            nibble <= (k < 8) ? boot_pat[4 * k +: 4] : 4'hC;
        end
        // two sync flops, then the store; the source mux adds one more
        @(posedge clk);
        strobe <= 1'b0;
        step();
        check(full, 1'b1);
        step();
        check(proc_data, boot_pat);
        repeat (4) step();
        check(proc_data, {boot_pat[31:4], 4'hC});
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            src_sel <= s[1:0];
            repeat (2) step();
            check(proc_data, (s == 0) ? row_data[6] : (s == 1) ?
                {boot_pat[31:4], 4'hC} : (s == 2) ? err_log
                : mode_reg);
        end
        do_reset();
        complete_run();
    end

endmodule : emd_datapath_bench
